//--- dsnz_addr_gen.sv
// Data address former for bank, access-bank and indexed literal-offset modes.
`timescale 1ns/1ps
module dsnz_addr_gen
	import dsnz_pkg::*;
(
	input wire logic [7:0] i_index,
	input wire logic i_win_sel,
	input wire logic i_ext_en,
	input wire logic [dsnz_pkg::BANK_W-1:0] i_bank_ptr,
	input wire logic [dsnz_pkg::ADDR_W-1:0] i_index_base,
	output logic [dsnz_pkg::ADDR_W-1:0] o_addr,
	output logic o_indexed
);
	wire indexed_w = !i_win_sel && i_ext_en && (i_index <= INDEX_MAX);
	wire [ADDR_W-1:0] bank_addr_w = {i_bank_ptr, i_index};
	wire [ADDR_W-1:0] access_addr_w = (i_index < ACCESS_SPLIT) ?
		{4'h0, i_index} : {ACCESS_HIGH_BANK, i_index};
	wire [ADDR_W-1:0] idx_addr_w = i_index_base + {4'h0, i_index};
	assign o_indexed = indexed_w;
	assign o_addr = indexed_w ? idx_addr_w :
		(i_win_sel ? bank_addr_w : access_addr_w);
endmodule

//--- dsnz_exec.sv
// Execution unit for the decrement-and-skip-if-nonzero instruction.
`timescale 1ns/1ps
module dsnz_exec
	import dsnz_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic [15:0] i_instr,
	input wire logic i_ext_en,
	input wire logic [dsnz_pkg::BANK_W-1:0] i_bank_ptr,
	input wire logic [dsnz_pkg::ADDR_W-1:0] i_index_base,
	input wire logic [7:0] i_rd_data,
	input wire logic i_next_two_word,
	output logic [1:0] o_phase,
	output logic o_busy,
	output logic o_done,
	output logic [dsnz_pkg::ADDR_W-1:0] o_addr,
	output logic o_rd_en,
	output logic o_wr_en,
	output logic [7:0] o_wr_data,
	output logic o_acc_we,
	output logic [7:0] o_acc_data,
	output logic o_discard,
	output logic o_nop,
	output logic o_indexed
);
	import dsnz_pkg::*;
	exec_state_t state_q, state_d;
	logic [1:0] phase_q;
	logic dest_q, win_q;
	logic [7:0] index_q, result_q;
	logic nz_q;
	logic [ADDR_W-1:0] addr_q;
	logic indexed_q;
	logic rd_en_q, wr_en_q, acc_we_q, done_q, discard_q, nop_q;
	logic [7:0] wr_data_q, acc_data_q;
	logic [ADDR_W-1:0] addr_w;
	logic indexed_w;

	wire is_op_w = i_instr[15:OPC_LSB] == OPCODE;
	wire take_w = (state_q == ST_IDLE) && i_start && is_op_w;
	wire ph_end_w = phase_q == PHASE_WRITE;
	wire [7:0] dec_w = i_rd_data - 8'h01;

	dsnz_addr_gen u_addr (
		.i_index(i_instr[7:0]),
		.i_win_sel(i_instr[WIN_BIT]),
		.i_ext_en(i_ext_en),
		.i_bank_ptr(i_bank_ptr),
		.i_index_base(i_index_base),
		.o_addr(addr_w),
		.o_indexed(indexed_w)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (take_w) state_d = ST_EXEC;
			ST_EXEC: if (ph_end_w)
				state_d = nz_q ? ST_SKIP1 : ST_IDLE;
			ST_SKIP1: if (ph_end_w)
				state_d = i_next_two_word ? ST_SKIP2 : ST_IDLE;
			ST_SKIP2: if (ph_end_w) state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			phase_q <= PHASE_DECODE;
			dest_q <= 1'b1;
			win_q <= 1'b1;
			index_q <= DATA_RST;
			result_q <= DATA_RST;
			nz_q <= 1'b0;
			addr_q <= '0;
			indexed_q <= 1'b0;
		end else if (i_ce) begin
			state_q <= state_d;
			phase_q <= (state_q == ST_IDLE) ? PHASE_DECODE : phase_q + 2'd1;
			if (take_w) begin
				dest_q <= i_instr[DEST_BIT];
				win_q <= i_instr[WIN_BIT];
				index_q <= i_instr[7:0];
				addr_q <= addr_w;
				indexed_q <= indexed_w;
			end
			if (state_q == ST_EXEC && phase_q == PHASE_READ) begin
				result_q <= dec_w;
				nz_q <= dec_w != 8'h00;
			end
		end
	end

	wire wr_w = state_q == ST_EXEC && phase_q == PHASE_PROC;
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rd_en_q <= 1'b0;
			wr_en_q <= 1'b0;
			acc_we_q <= 1'b0;
			wr_data_q <= DATA_RST;
			acc_data_q <= DATA_RST;
			done_q <= 1'b0;
			discard_q <= 1'b0;
			nop_q <= 1'b0;
		end else if (i_ce) begin
			rd_en_q <= take_w;
			wr_en_q <= wr_w && dest_q;
			acc_we_q <= wr_w && !dest_q;
			if (wr_w) begin
				wr_data_q <= result_q;
				acc_data_q <= result_q;
			end
			discard_q <= (state_q == ST_EXEC) && ph_end_w && nz_q;
			nop_q <= state_d == ST_SKIP1 || state_d == ST_SKIP2;
			done_q <= (state_q != ST_IDLE) && (state_d == ST_IDLE);
		end
	end

	assign o_phase = phase_q;
	assign o_busy = state_q != ST_IDLE;
	assign o_done = done_q;
	assign o_addr = addr_q;
	assign o_rd_en = rd_en_q;
	assign o_wr_en = wr_en_q;
	assign o_wr_data = wr_data_q;
	assign o_acc_we = acc_we_q;
	assign o_acc_data = acc_data_q;
	assign o_discard = discard_q;
	assign o_nop = nop_q;
	assign o_indexed = indexed_q;

	property p_dec;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && state_q == ST_EXEC && phase_q == PHASE_READ) ##1 i_ce
		|=> (result_q == $past(i_rd_data, 2) - 8'h01);
	endproperty
	a_dec: assert property (p_dec) else $error("bad decrement");

	property p_dest;
		@(posedge i_clk_sys) disable iff (i_rst)
		(o_wr_en || o_acc_we) |-> (o_wr_en != o_acc_we) && o_wr_en == dest_q;
	endproperty
	a_dest: assert property (p_dest) else $error("bad destination");

	property p_skip;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_discard |-> nz_q && result_q != 8'h00;
	endproperty
	a_skip: assert property (p_skip) else $error("bad discard");

	property p_noskip_len;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && take_w) ##1 (i_ce [*4]) ##0 !nz_q |=> !o_busy;
	endproperty
	a_noskip_len: assert property (p_noskip_len) else $error("not 1 cycle");

	property p_skip2;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && state_q == ST_SKIP1 && ph_end_w && i_next_two_word)
		|=> state_q == ST_SKIP2;
	endproperty
	a_skip2: assert property (p_skip2) else $error("no second skip");

	property p_bank;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && take_w && i_instr[WIN_BIT])
		|=> o_addr == {$past(i_bank_ptr), $past(i_instr[7:0])};
	endproperty
	a_bank: assert property (p_bank) else $error("bad bank address");

	property p_idx;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_ce && take_w) |=> o_indexed == (!win_q && $past(i_ext_en)
			&& index_q <= INDEX_MAX);
	endproperty
	a_idx: assert property (p_idx) else $error("bad indexed mode");

	property p_phase;
		@(posedge i_clk_sys) disable iff (i_rst)
		(o_wr_en || o_acc_we) |-> phase_q == PHASE_WRITE;
	endproperty
	a_phase: assert property (p_phase) else $error("write off phase");

	c_noskip: cover property (@(posedge i_clk_sys) o_done && !o_nop);
	c_skip: cover property (@(posedge i_clk_sys) o_discard);
	c_skip2: cover property (@(posedge i_clk_sys) state_q == ST_SKIP2);
	c_acc: cover property (@(posedge i_clk_sys) o_acc_we);
endmodule

//--- dsnz_mem_model.sv
// Behavioural data memory that serves the execution unit.
`timescale 1ns/1ps
module dsnz_mem_model
	import dsnz_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rd_en,
	input wire logic i_wr_en,
	input wire logic [dsnz_pkg::ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wr_data,
	output logic [7:0] o_rd_data
);
	logic [7:0] mem [0:4095];
	initial begin
		o_rd_data = 8'h00;
		for (int i = 0; i < 4096; i++) begin
			mem[i] = i[7:0];
		end
	end
	// Outside a read the bus shows the inverse of its last value.
	always @(posedge i_clk_sys) begin
		o_rd_data <= i_rd_en ? mem[i_addr] : ~o_rd_data;
		if (i_wr_en) begin
			mem[i_addr] <= i_wr_data;
		end
	end
endmodule

//--- dsnz_pkg.sv
// Constants and types for the decrement-and-skip-if-nonzero execution unit.
package dsnz_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int BANK_W = 4;
	localparam logic [5:0] OPCODE = 6'h13;
	localparam int OPC_LSB = 10;
	localparam int DEST_BIT = 9;
	localparam int WIN_BIT = 8;
	localparam logic [7:0] INDEX_MAX = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [1:0] PHASE_DECODE = 2'd0;
	localparam logic [1:0] PHASE_READ = 2'd1;
	localparam logic [1:0] PHASE_PROC = 2'd2;
	localparam logic [1:0] PHASE_WRITE = 2'd3;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_SKIP1 = 4'b0100,
		ST_SKIP2 = 4'b1000
	} exec_state_t;
endpackage

//--- tb_decrement_skip_if_nonzero.sv
// Self-checking testbench for the decrement-and-skip execution unit.
`timescale 1ns/1ps
module tb_decrement_skip_if_nonzero;
	import dsnz_pkg::*;
	logic clk = 1'b0, rst = 1'b1, start = 1'b0, ext = 1'b0, two = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [3:0] bank = 4'h0;
	logic [11:0] base = 12'h000, addr;
	logic [7:0] rd_data, wr_data, acc_data;
	logic [1:0] phase;
	logic done, rd_en, wr_en, acc_we, discard, indexed;
	logic ce = 1'b1, busy, nop;
	int n_mismatch = 0;
	int n_checks = 0;
	always #10 clk = ~clk;
	dsnz_exec i_dsnz_exec(.i_clk_sys(clk), .i_rst(rst), .i_ce(ce),
		.i_start(start), .i_instr(instr), .i_ext_en(ext),
		.i_bank_ptr(bank), .i_index_base(base), .i_rd_data(rd_data),
		.i_next_two_word(two), .o_phase(phase), .o_busy(busy), .o_done(done),
		.o_addr(addr), .o_rd_en(rd_en), .o_wr_en(wr_en),
		.o_wr_data(wr_data), .o_acc_we(acc_we), .o_acc_data(acc_data),
		.o_discard(discard), .o_nop(nop), .o_indexed(indexed));
	dsnz_mem_model i_dsnz_mem_model(.i_clk_sys(clk), .i_rd_en(rd_en),
		.i_wr_en(wr_en), .i_addr(addr), .i_wr_data(wr_data),
		.o_rd_data(rd_data));
	task chk(input string what, input logic [11:0] e, input logic [11:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task go(input logic [15:0] ins, input logic tw, input logic [11:0] ea,
		input logic [7:0] ev, input int hold);
		int n;
		int nn;
		int ec;
		int en;
		logic dsc, wr, ac;
		logic [11:0] a;
		logic [7:0] v;
		logic [1:0] ph;
		@(posedge clk);
		instr <= ins;
		start <= 1'b1;
		two <= tw;
		@(posedge clk);
		start <= 1'b0;
		#1;
		n = 0;
		nn = 0;
		{dsc, wr, ac, a, v, ph} = '0;
		// Sampling starts right after the taking edge: the read pulse
		// stands only in the first cycle. A hold freezes the unit early on.
		repeat (21) begin
			if (rd_en === 1'b1) {a, ph} = {addr, phase};
			if (wr_en === 1'b1) {wr, v} = {1'b1, wr_data};
			if (acc_we === 1'b1) {ac, v} = {1'b1, acc_data};
			if (discard === 1'b1) dsc = 1'b1;
			if (nop === 1'b1) nn++;
			if (n >= 20 || done === 1'b1) break;
			@(posedge clk);
			ce <= !(n >= 1 && n <= hold);
			#1;
			n++;
		end
		if (done !== 1'b1) begin
			n_mismatch++;
			results();
		end
		ec = (ev == 8'h00 ? 4 : (tw ? 12 : 8)) + hold;
		en = ev == 8'h00 ? 0 : (tw ? 8 : 4);
		chk("address", ea, a);
		// The read request is issued in decode so the data stands in read.
		chk("phase", {10'h000, PHASE_DECODE}, {10'h000, ph});
		chk("nop cycles", en[11:0], nn[11:0]);
		chk("busy", 12'h000, {11'h000, busy});
		chk("result", {4'h0, ev}, {4'h0, v});
		chk("reg write", {11'h000, ins[DEST_BIT]}, {11'h000, wr});
		chk("acc write", {11'h000, !ins[DEST_BIT]}, {11'h000, ac});
		chk("discard", {11'h000, ev != 8'h00}, {11'h000, dsc});
		chk("cycles", ec[11:0], n[11:0]);
	endtask
	task t_skip_acc;
		@(posedge clk);
		bank <= 4'h3;
		go({OPCODE, 2'b01, 8'h05}, 1'b0, 12'h305, 8'h04, 3);
		$display("test skip_acc done");
	endtask
	task t_writeback;
		@(posedge clk);
		bank <= 4'h2;
		go({OPCODE, 2'b11, 8'h01}, 1'b0, 12'h201, 8'h00, 0);
		go({OPCODE, 2'b11, 8'h01}, 1'b1, 12'h201, 8'hff, 0);
		$display("test writeback done");
	endtask
	task t_access;
		go({OPCODE, 2'b10, 8'h20}, 1'b0, 12'h020, 8'h1f, 0);
		@(posedge clk);
		ext <= 1'b1;
		base <= 12'h400;
		go({OPCODE, 2'b10, 8'h70}, 1'b0, 12'hf70, 8'h6f, 0);
		chk("indexed", 12'h000, {11'h000, indexed});
		go({OPCODE, 2'b10, 8'h5f}, 1'b0, 12'h45f, 8'h5e, 0);
		chk("indexed", 12'h001, {11'h000, indexed});
		$display("test access done");
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_skip_acc();
		t_writeback();
		t_access();
		results();
	end
endmodule
